// ### core/wds_top.sv
// Watchdog with shared postscaler, sleep control, reset-hold timer,
// timeout and power-down status flags, and a filtered supply-drop reset.
// Assumes the processor core pulses its instruction strobes for one cycle on clk
// and that sys_rst is the power-up reset. Registers sit on an APB slave.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module wds_top import wds_pkg::*; #(
  parameter int WDT_BASE_CYCLES = WDT_BASE_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // Clock and power-up reset.
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction strobes from the processor core.
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  // Asynchronous pins and analog comparator outputs.
  input wire logic reset_pin_n,
  input wire logic supply_below_normal,
  input wire logic supply_below_low,
  input wire logic watchdog_fuse_enable,
  // Reset pin drive; never enabled.
  output logic reset_pin_oe,
  // Core control and status.
  output logic cpu_reset,
  output logic core_clk_en,
  output logic osc_drive_en,
  output logic io_hold,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic [7:0] option_control
);

  // Assertions share the fabric clock and the power-up reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Synchronised pin levels.
  logic ext_rst_active;
  logic below_normal;
  logic below_low;
  logic fuse_en;
  // Current and next device state.
  wds_state_t state;
  wds_state_t next_state;
  // Watchdog base counter, postscaler and their decoded limits.
  logic [CNT_W-1:0] base_cnt;
  logic [7:0] post_cnt;
  logic [7:0] post_last;
  logic base_last;
  logic wdt_fire;
  logic wdt_clr;
  // Reset-hold counter.
  logic [CNT_W-1:0] hold_cnt;
  // Supply-drop filter.
  logic [4:0] pfd_cnt;
  logic supply_low;
  logic pfd_trip;
  // Any event that forces a device reset.
  logic dev_reset_req;
  // Instruction strobes only count while the core runs.
  logic run_sleep;
  logic run_clear;
  // APB decode.
  logic apb_access;
  logic apb_done;

  // Last postscaler count for the current option value; zero when unassigned.
  function automatic logic [7:0] wds_post_last(input logic [7:0] opt);
    if (opt[OPT_PRESCALER_ASSIGN]) begin
      return 8'hFF >> (3'h7 - opt[OPT_PRESCALE_LSB +: 3]);
    end
    return 8'h00;
  endfunction

  // Pins come from outside the clock domain. The reset pin is inverted so that
  // its synchronised copy reads high while the pin is held low.
  wds_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({watchdog_fuse_enable, supply_below_low, supply_below_normal, reset_pin_n}),
    .reset_level(4'h1),
    .sync_out({fuse_en, below_low, below_normal, ext_rst_active})
  );

  // Instruction strobes are honoured only while the core has a clock.
  assign run_sleep = (state == ST_RUN) && sleep_instr;
  assign run_clear = (state == ST_RUN) && watchdog_clear_instr;

  // Supply comparator choice follows the threshold select bit.
  assign supply_low = option_control[OPT_LOW_THRESHOLD_SELECT] ? below_low : below_normal;

  // Count consecutive low samples while the detector is enabled; saturate at trip.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pfd_cnt <= 5'h00;
    end else if (!option_control[OPT_SUPPLY_DROP_ENABLE] || !supply_low) begin
      pfd_cnt <= 5'h00;
    end else if (pfd_cnt != PFD_TRIP_CNT) begin
      pfd_cnt <= pfd_cnt + 5'h01;
    end
  end

  // A drop must outlast the filter time, so short noise spikes are ignored.
  assign pfd_trip = (pfd_cnt == PFD_TRIP_CNT);

  // Postscaler limit and base wrap point.
  assign post_last = wds_post_last(option_control);
  assign base_last = (base_cnt == CNT_W'(WDT_BASE_CYCLES - 1));

  // Timeout fires only with the fuse set, in run or sleep, whatever the flags hold.
  assign wdt_fire = fuse_en && (state != ST_HOLD) && base_last && (post_cnt == post_last);

  // Clear on the clear and sleep strobes, on timeout, and throughout reset hold,
  // which also covers every wake-up since waking always passes through hold.
  assign wdt_clr = (state == ST_HOLD) || run_clear || run_sleep || wdt_fire || !fuse_en;

  // The watchdog counts on clk, not on the gated core clock, so sleep does not stop it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_cnt <= '0;
    end else if (wdt_clr || dev_reset_req) begin
      base_cnt <= '0;
    end else if (base_last) begin
      base_cnt <= '0;
    end else begin
      base_cnt <= base_cnt + CNT_W'(1);
    end
  end

  // The postscaler advances once per base period.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      post_cnt <= 8'h00;
    end else if (wdt_clr || dev_reset_req) begin
      post_cnt <= 8'h00;
    end else if (base_last) begin
      post_cnt <= post_cnt + 8'h01;
    end
  end

  // Every reset source forces hold; only the pin keeps it there, as hold reloads the option value with the supply detector off.
  assign dev_reset_req = ext_rst_active || pfd_trip || wdt_fire;

  // Device state sequencing.
  always_comb begin
    next_state = state;
    if (dev_reset_req) begin
      next_state = ST_HOLD;
    end else begin
      case (state)
        ST_HOLD: begin
          // Leave hold once the interval has run out with no source active.
          if (hold_cnt == CNT_W'(HOLD_CYCLES - 1)) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          // Sleep runs whatever the power-down flag holds.
          if (run_sleep) begin
            next_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // Only a reset source leaves sleep.
          next_state = ST_SLEEP;
        end
        default: begin
          next_state = ST_HOLD;
        end
      endcase
    end
  end

  // State register; power-up starts in hold.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Hold interval counter restarts on each reset event, so the interval is
  // measured from the release of the last source.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt <= '0;
    end else if (dev_reset_req || state != ST_HOLD) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + CNT_W'(1);
    end
  end

  // Core-facing controls are registered from the next state so they match it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_reset <= 1'b1;
      core_clk_en <= 1'b0;
      osc_drive_en <= 1'b1;
      io_hold <= 1'b0;
    end else begin
      cpu_reset <= (next_state == ST_HOLD);
      core_clk_en <= (next_state == ST_RUN);
      osc_drive_en <= (next_state != ST_SLEEP);
      io_hold <= (next_state == ST_SLEEP);
    end
  end

  // The reset pin is an input only to this block; a watchdog reset stays internal.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_pin_oe <= 1'b0;
    end else begin
      reset_pin_oe <= 1'b0;
    end
  end

  // Status flags. Power-up sets both; timeout outranks the instruction strobes
  // so a timeout in the same cycle as a clear is never lost. Pin and supply
  // resets do not touch the flags, which gives the cause table after reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (wdt_fire) begin
      timeout_flag <= 1'b0;
    end else if (run_sleep) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (run_clear) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end
  end

  // APB: one wait state, so read data and error come from registers.
  assign apb_access = psel && penable;
  assign apb_done = apb_access && pready;

  // Ready rises one cycle into the access phase and falls after completion.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access && !pready;
      pslverr <= (paddr != OPTION_CONTROL_OFS) && (paddr != SLEEP_STATUS_OFS);
      prdata <= 32'h0000_0000;
      if (!pwrite && paddr == SLEEP_STATUS_OFS) begin
        prdata[STS_TIMEOUT_FLAG] <= timeout_flag;
        prdata[STS_POWERDOWN_FLAG] <= powerdown_flag;
        prdata[STS_FUSE_ENABLE] <= fuse_en;
        prdata[STS_CPU_RESET] <= cpu_reset;
        prdata[STS_ASLEEP] <= io_hold;
      end
    end
  end

  // Option register is write-only and reloads its reset value during every
  // device reset; writes made during hold are dropped for that reason.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      option_control <= OPTION_RESET;
    end else if (next_state == ST_HOLD) begin
      option_control <= OPTION_RESET;
    end else if (apb_done && pwrite && paddr == OPTION_CONTROL_OFS) begin
      option_control <= pwdata[7:0];
    end
  end

  // Sleep entry sets timeout and clears power-down on the next edge.
  AST_SLEEP_FLAGS: assert property (run_sleep && !dev_reset_req |=> timeout_flag && !powerdown_flag && io_hold)
    else $error("Sleep entry flags wrong.");

  // Clear instruction sets both flags unless a timeout or a sleep strobe wins.
  AST_CLEAR_FLAGS: assert property (run_clear && !run_sleep && !wdt_fire |=> timeout_flag && powerdown_flag)
    else $error("Clear instruction flags wrong.");

  // Timeout clears only the timeout flag and enters reset hold.
  AST_TIMEOUT_RESET: assert property (wdt_fire |=> !timeout_flag && cpu_reset
    && powerdown_flag == $past(powerdown_flag))
    else $error("Timeout did not reset with correct flags.");

  // The reset pin is never driven.
  AST_PIN_UNDRIVEN: assert property (!reset_pin_oe)
    else $error("Reset pin driven.");

  // In sleep the core clock and oscillator are off and pins are frozen.
  AST_SLEEP_STOPPED: assert property (io_hold |-> !core_clk_en && !osc_drive_en && !cpu_reset)
    else $error("Clock running during sleep.");

  // A pin reset while not running leaves both flags alone.
  AST_PIN_KEEPS_FLAGS: assert property (ext_rst_active && state != ST_RUN && !wdt_fire
    |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("Pin reset changed flags.");

  // Any wake from sleep clears the watchdog and enters hold.
  AST_WAKE_CLEARS: assert property (state == ST_SLEEP && dev_reset_req
    |=> base_cnt == '0 && post_cnt == 8'h00 && state == ST_HOLD)
    else $error("Wake did not clear watchdog.");

  // Hold releases only after the full interval.
  AST_HOLD_LENGTH: assert property (state == ST_HOLD && next_state == ST_RUN
    |-> hold_cnt == CNT_W'(HOLD_CYCLES - 1))
    else $error("Reset hold released early.");

  // A filtered supply drop holds the processor in reset.
  AST_PFD_RESET: assert property (pfd_trip |=> cpu_reset ##1 cpu_reset)
    else $error("Supply drop did not reset.");

  // A cleared fuse never lets the watchdog fire.
  AST_FUSE_OFF: assert property (!fuse_en |-> !wdt_fire)
    else $error("Watchdog fired with fuse off.");

  // Main scenarios.
  COV_SLEEP: cover property (run_sleep);
  COV_WDT_WAKE: cover property (state == ST_SLEEP && wdt_fire);
  COV_WDT_RUN: cover property (state == ST_RUN && wdt_fire);
  COV_PFD: cover property (pfd_trip && state == ST_RUN);

endmodule

// ### core/wds_pkg.sv
// Shared constants for the watchdog, sleep and reset-status block.
// Assumes a single 200 MHz fabric clock; all slower rates are derived from it.
package wds_pkg;

  // Clock period of the fabric clock in nanoseconds.
  localparam int CLK_NS = 5;

  // Nominal watchdog period without prescaler, in milliseconds.
  localparam int WDT_PERIOD_MS = 14;
  // Watchdog base period in clock cycles; rounded down as a longest time.
  localparam int WDT_BASE_CYC = (WDT_PERIOD_MS * 1000000) / CLK_NS;

  // Nominal reset-hold interval, in milliseconds.
  localparam int HOLD_MS = 7;
  // Reset-hold interval in clock cycles; rounded up as a least time.
  localparam int HOLD_CYC = (HOLD_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // Supply must stay low longer than this many nanoseconds to trip.
  localparam int PFD_MIN_NS = 100;
  // Least filter time in cycles, rounded up.
  localparam int PFD_MIN_CYC = (PFD_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Low samples needed to exceed the filter time.
  localparam logic [4:0] PFD_TRIP_CNT = 5'(PFD_MIN_CYC + 1);

  // Width of the base and hold counters; covers both cycle counts.
  localparam int CNT_W = 22;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OPTION_CONTROL_OFS = 8'h00;
  localparam logic [7:0] SLEEP_STATUS_OFS = 8'h04;

  // Reset value of the option register.
  localparam logic [7:0] OPTION_RESET = 8'h3F;

  // Field positions in the option register.
  localparam int OPT_LOW_THRESHOLD_SELECT = 7;
  localparam int OPT_SUPPLY_DROP_ENABLE = 6;
  localparam int OPT_PRESCALER_ASSIGN = 3;
  localparam int OPT_PRESCALE_LSB = 0;

  // Field positions in the status register.
  localparam int STS_TIMEOUT_FLAG = 4;
  localparam int STS_POWERDOWN_FLAG = 3;
  localparam int STS_FUSE_ENABLE = 2;
  localparam int STS_CPU_RESET = 1;
  localparam int STS_ASLEEP = 0;

  // Device operating states.
  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP} wds_state_t;

endpackage

// ### core/wds_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are slow levels; a pulse shorter than one cycle may fall between edges and be lost.
`timescale 1ns/1ps
module wds_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_level,
  output logic [WIDTH-1:0] sync_out
);

  // Each bit has its own pair of flip-flops; the first stage is read only by the second.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta;
      // Both stages reset to zero; the reset level is applied on the output side.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta <= 1'b0;
        end else begin
          meta <= async_in[gi];
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync_out[gi] <= 1'b0;
        end else begin
          sync_out[gi] <= meta ^ reset_level[gi];
        end
      end
    end
  endgenerate

endmodule

// ### sim/wds_core_model.sv
// Processor core stand-in that issues watchdog-clear and sleep strobes.
// Assumes the block takes a one-cycle strobe only while core_clk_en is high.
`timescale 1ns/1ps
module wds_core_model (
  // Clock and core clock enable.
  input wire logic clk,
  input wire logic core_clk_en,
  // Interval of the periodic clears in cycles; zero stops them.
  input wire logic [7:0] clr_period,
  // Instruction strobes.
  output logic watchdog_clear_instr,
  output logic sleep_instr
);
  int cnt = 0; // Cycles since the last periodic clear.
  logic per_clr = 1'b0; // Periodic clear strobe.
  logic one_clr = 1'b0; // Single clear strobe asked for by pulse.
  logic one_slp = 1'b0; // Single sleep strobe asked for by pulse.

  // Each strobe source has one process of its own; the ports merge them, so
  // stopping the periodic clears can never leave a strobe stuck high.
  assign watchdog_clear_instr = per_clr || one_clr;
  assign sleep_instr = one_slp;

  // Periodic clears, well inside the watchdog period; a halted core fetches nothing.
  always @(posedge clk) begin
    cnt <= (clr_period == 8'h00 || cnt + 1 >= clr_period) ? 0 : cnt + 1;
    per_clr <= (clr_period != 8'h00) && (core_clk_en === 1'b1) && (cnt == 0);
  end

  // One strobe on an edge where the core runs, whatever the flags read.
  task automatic pulse(input logic slp);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (core_clk_en !== 1'b1 && k < 400);
    if (slp) begin
      one_slp <= 1'b1;
    end else begin
      one_clr <= 1'b1;
    end
    @(posedge clk);
    one_slp <= 1'b0;
    one_clr <= 1'b0;
  endtask
endmodule

// ### sim/test_watchdog_sleep_reset_status.sv
// Self-checking bench for the watchdog, sleep and reset-status block.
// Assumes wds_top with shortened counts; the core model drives the strobes.
`timescale 1ns/1ps
module test_watchdog_sleep_reset_status import wds_pkg::*; ;
  localparam int BASE = 50; // Shortened watchdog base period.
  localparam int HOLD = 20; // Shortened reset-hold interval.
  logic clk, sys_rst, psel, penable, pwrite, reset_pin_n, fuse, pready, pslverr, err;
  logic clr_i, slp_i, pin_oe, cpu_reset, clk_en, osc_en, io_hold, to_f, pd_f;
  logic [1:0] sup; // Bit 0 normal comparator, bit 1 lowered comparator.
  logic [7:0] paddr, clr_period, opt, exp_opt;
  logic [31:0] pwdata, prdata, rd;
  logic exp_to, exp_pd; // Model of the two status flags.
  int bad_count, tests_run, c, p, len;
  int period_q[$]; // Expected watchdog periods per prescale setting.

  wds_top #(.WDT_BASE_CYCLES(BASE), .HOLD_CYCLES(HOLD)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_clear_instr(clr_i),
    .sleep_instr(slp_i), .reset_pin_n(reset_pin_n), .supply_below_normal(sup[0]),
    .supply_below_low(sup[1]), .watchdog_fuse_enable(fuse), .reset_pin_oe(pin_oe),
    .cpu_reset(cpu_reset), .core_clk_en(clk_en), .osc_drive_en(osc_en), .io_hold(io_hold),
    .timeout_flag(to_f), .powerdown_flag(pd_f), .option_control(opt));

  wds_core_model i_core (.clk(clk), .core_clk_en(clk_en), .clr_period(clr_period),
    .watchdog_clear_instr(clr_i), .sleep_instr(slp_i));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog of the bench; the whole sequence needs far fewer cycles.
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end

  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      chk(40'h0, 40'h1);
    end
  endtask

  // Counts edges until cpu_reset is high, giving up at lim.
  task automatic wait_rst(input int lim, output int n);
    n = 0;
    while (cpu_reset !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Counts edges until the core runs again.
  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(cpu_reset === 1'b0 && clk_en === 1'b1) && n < 300);
  endtask

  // Compares ports and the status register with the model in run state.
  task automatic chk_run();
    @(negedge clk);
    chk({pin_oe, to_f, pd_f, opt}, {1'b0, exp_to, exp_pd, exp_opt});
    apb(1'b0, SLEEP_STATUS_OFS, 32'h0);
    chk({err, rd}, {28'h0, exp_to, exp_pd, 3'b100});
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_pin_n = 1'b1;
    sup = 2'b00;
    fuse = 1'b1;
    clr_period = 8'h00;
    bad_count = 0;
    tests_run = 0;
    exp_to = 1'b1;
    exp_pd = 1'b1;
    exp_opt = OPTION_RESET;
    period_q = {BASE, BASE * 2, BASE * 4, BASE * 8};
    void'($urandom(32'hD57B3CD2));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    wait_run(c);
    chk_rng(c, HOLD, HOLD + 6);
    chk_run();
    apb(1'b1, SLEEP_STATUS_OFS, 32'hFFFFFFFF);
    chk_run();
    apb(1'b0, OPTION_CONTROL_OFS, 32'h0);
    chk({err, rd}, 40'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk({err, rd}, {8'h1, 32'h0});
    // Unassigned and prescale 0 to 2: periodic clears hold it off, then it must fire on time.
    for (int i = -1; i < 3; i++) begin
      exp_opt = (i < 0) ? 8'h00 : 8'(8 + i);
      exp_opt = exp_opt | 8'($urandom & 32'h30);
      apb(1'b1, OPTION_CONTROL_OFS, ($urandom & 32'hFFFFFF00) | exp_opt);
      // The write lands at the completing edge; look once it has settled.
      @(negedge clk);
      chk(opt, exp_opt);
      clr_period <= 8'd20;
      wait_rst(300, c);
      chk_rng(c, 300, 300);
      clr_period <= 8'h00;
      i_core.pulse(1'b0);
      wait_rst(2000, c);
      p = period_q.pop_front();
      chk_rng(c, p - 2, p + 4);
      exp_to = 1'b0;
      exp_opt = OPTION_RESET;
      wait_run(c);
      chk_rng(c, HOLD, HOLD + 6);
      chk_run();
      i_core.pulse(1'b0);
      exp_to = 1'b1;
      exp_pd = 1'b1;
      chk_run();
    end
    // Sleep, then a watchdog wake-up.
    exp_opt = 8'h00;
    apb(1'b1, OPTION_CONTROL_OFS, 32'h0);
    i_core.pulse(1'b1);
    exp_pd = 1'b0;
    @(negedge clk);
    chk({io_hold, clk_en, osc_en, to_f, pd_f}, 5'b10010);
    wait_rst(2000, c);
    chk_rng(c, BASE - 2, BASE + 4);
    exp_to = 1'b0;
    exp_opt = OPTION_RESET;
    wait_run(c);
    chk_run();
    // Sleep again with the powerdown flag already low, then a pin wake-up.
    i_core.pulse(1'b1);
    exp_to = 1'b1;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk({io_hold, clk_en, to_f, pd_f}, 4'b1010);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    wait_rst(10, c);
    chk_rng(c, 1, 5);
    reset_pin_n <= 1'b1;
    wait_run(c);
    chk_run();
    // A pin pulse in run state resets but keeps both flags.
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(cpu_reset, 40'h1);
    reset_pin_n <= 1'b1;
    wait_run(c);
    chk_run();
    // Supply drop with the detector off must do nothing.
    sup <= 2'b01;
    wait_rst(40, c);
    sup <= 2'b00;
    chk_rng(c, 40, 40);
    // Normal and lowered threshold: only the selected comparator counts.
    for (int j = 0; j < 2; j++) begin
      exp_opt = j ? 8'hCF : 8'h4F;
      apb(1'b1, OPTION_CONTROL_OFS, {24'h0, exp_opt});
      sup[1 - j] <= 1'b1;
      wait_rst(40, c);
      sup <= 2'b00;
      chk_rng(c, 40, 40);
      len = 5 + $urandom % 12;
      sup[j] <= 1'b1;
      wait_rst(len, c);
      sup <= 2'b00;
      wait_rst(8, c);
      chk_rng(c, 8, 8);
      sup[j] <= 1'b1;
      wait_rst(40, c);
      sup <= 2'b00;
      chk_rng(c, 21, 27);
      exp_opt = OPTION_RESET;
      wait_run(c);
      chk_run();
    end
    // A second power-up reset mid-run sets both flags again.
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    exp_pd = 1'b1;
    wait_run(c);
    chk_rng(c, HOLD, HOLD + 6);
    chk_run();
    // Fuse off: the watchdog never fires.
    fuse <= 1'b0;
    apb(1'b1, OPTION_CONTROL_OFS, 32'h0);
    wait_rst(400, c);
    chk_rng(c, 400, 400);
    finish_test();
  end
endmodule
